// >>> src/fwse_seq.sv
// Flash row write and erase sequencer with keyed start.
// Assumes a flash array on the same clock with combinational read data.
//
// Contract
// - Row from address 14:5, latch from 4:0.
// - One operation never spans two rows.
// - Latches return blank after program or erase.
// - Latch mode loads addressed latch only.
// - Program mode writes all latches to row.
// - Erase mode erases the addressed row.
// - Protected target: clear start, flag error.
// - Load or program needs unbroken unlock.
// - Programming never erases automatically.
// - Erase covers exactly one row.
// - Program always writes all 32 words.
// - Config-space read outside ranges gives zero.
// - User-ID words readable and writable.
// - ID, config, calibration words read-only.
// - Error on protection, reset, broken unlock.
// - Error flag sticky; software sets or clears.
// - Keys 55h then AAh, then start.
// - Completion sets done flag and interrupt.
// - Read loads data pair next cycle.
`timescale 1ns/1ps
`include "fwse_defines.svh"
module fwse_seq #(
	parameter int ROW_WORDS = `FWSE_ROW_WORDS,
	parameter int DW        = 14,
	parameter int AW        = 15
)(
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	input  wire logic          i_dev_rst,
	input  wire logic          i_addr_we,
	input  wire logic [AW-1:0] i_addr_wdata,
	input  wire logic          i_data_we,
	input  wire logic [DW-1:0] i_data_wdata,
	input  wire logic          i_ctrl_we,
	input  wire logic [7:0]    i_ctrl_wdata,
	input  wire logic          i_key_we,
	input  wire logic [7:0]    i_key_wdata,
	input  wire logic          i_seq_break,
	input  wire logic          i_done_clr,
	input  wire logic          i_done_ie,
	input  wire logic [DW-1:0] i_fl_rdata,
	input  wire logic          i_fl_wp,
	input  wire logic          i_fl_done,
	output logic [AW-1:0]      o_flash_addr,
	output logic [DW-1:0]      o_flash_word,
	output logic [7:0]         o_ctrl,
	output logic               o_mem_op_done_flag,
	output logic               o_irq,
	output logic               o_fl_cfg,
	output logic               o_fl_erase,
	output logic               o_fl_prog_we,
	output logic [AW-1:0]      o_fl_prog_addr,
	output logic [DW-1:0]      o_fl_prog_data
);
	localparam int IW = $clog2(ROW_WORDS);
	localparam logic [IW-1:0] LAST_IDX = IW'(ROW_WORDS - 1);

	if (ROW_WORDS != 32 || DW != 14 || AW != 15) begin : g_chk
		$error("fwse_seq: row of 32 words of 14 bits only");
	end

	// ****************************************************************
	// Address decoding
	// ****************************************************************
	function automatic logic uid_addr(input logic [AW-1:0] a);
		return a <= `FWSE_UID_HI;
	endfunction

	function automatic logic cfg_readable(input logic [AW-1:0] a);
		return uid_addr(a) ||
			(a >= `FWSE_ID_LO && a <= `FWSE_CFGW_HI) ||
			(a >= `FWSE_DIA_LO && a <= `FWSE_DIA_HI);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	fwse_latch_if #(.AW(IW), .DW(DW)) lat ();

	fwse_latch_mem #(.DEPTH(ROW_WORDS), .AW(IW), .DW(DW)) u_mem (
		.i_clk (i_clk),
		.lp    (lat.mem)
	);

	fwse_pkg::fwse_state_e state;
	fwse_pkg::fwse_key_e   key;
	logic                  cfg_sel;
	logic                  latch_only_select;
	logic                  erase_sel;
	logic                  program_erase_enable;
	logic                  werr;
	logic                  wr;
	logic                  rd;
	logic [IW-1:0]         idx;
	logic [ROW_WORDS-1:0]  loaded;
	logic                  s1_v;
	logic                  s1_ld;
	logic [IW-1:0]         s1_idx;
	logic                  lat_we;
	logic [IW-1:0]         lat_waddr;
	logic [DW-1:0]         lat_wdata;
	logic                  next_done;

	assign lat.we    = lat_we;
	assign lat.waddr = lat_waddr;
	assign lat.wdata = lat_wdata;
	assign lat.raddr = idx;

	// ****************************************************************
	// Request decoding
	// ****************************************************************
	wire idle      = (state == fwse_pkg::FWSE_IDLE);
	wire self_wr   = (state == fwse_pkg::FWSE_LOAD) ||
		(state == fwse_pkg::FWSE_EWAIT) ||
		(state == fwse_pkg::FWSE_PROG) ||
		(state == fwse_pkg::FWSE_PWAIT);
	wire wr_req    = i_ctrl_we & i_ctrl_wdata[`FWSE_CB_WR];
	wire new_cfg   = i_ctrl_wdata[`FWSE_CB_CFG];
	wire new_latch_only_select  = i_ctrl_wdata[`FWSE_CB_LATCH_ONLY_SELECT];
	wire new_erase = i_ctrl_wdata[`FWSE_CB_FREE];
	wire any_acc   = i_addr_we | i_data_we | i_ctrl_we | i_key_we;
	wire key1_hit  = i_key_we & (i_key_wdata == `FWSE_KEY1);
	wire key2_hit  = i_key_we & (i_key_wdata == `FWSE_KEY2);
	wire armed     = (key == fwse_pkg::FWSE_K_ARMED);
	wire key_step  = (key == fwse_pkg::FWSE_K_FIRST && key2_hit) ||
		(armed && wr_req);
	wire seq_broken = (key != fwse_pkg::FWSE_K_IDLE) &&
		(i_seq_break || (any_acc && !key_step));
	wire start     = idle & wr_req & armed &
		i_ctrl_wdata[`FWSE_CB_PROGRAM_ERASE_ENABLE] & !i_seq_break;
	// Configuration space accepts self-writes only to the user-ID words.
	wire prot      = new_cfg ? !uid_addr(o_flash_addr) : i_fl_wp;
	wire is_load   = new_latch_only_select & !new_erase;
	wire blocked   = start & !is_load & prot;
	wire accept    = start & !blocked;
	wire rd_req    = idle & i_ctrl_we & i_ctrl_wdata[`FWSE_CB_RD] & !wr_req;
	wire ewait_end = (state == fwse_pkg::FWSE_EWAIT) & i_fl_done;
	// The array may only finish once the last streamed word left.
	wire pwait_end = (state == fwse_pkg::FWSE_PWAIT) & i_fl_done &
		!s1_v & !o_fl_prog_we;
	wire op_end    = ewait_end | pwait_end;
	wire hw_err    = blocked | seq_broken | (i_dev_rst & self_wr);

	// ****************************************************************
	// Unlock sequence
	// ****************************************************************
	// Any foreign access between the steps cancels the sequence, which
	// is what makes the order exact; idle cycles between the steps are allowed.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			key <= fwse_pkg::FWSE_K_IDLE;
		end else if (i_dev_rst || seq_broken || i_seq_break) begin
			key <= fwse_pkg::FWSE_K_IDLE;
		end else if (key == fwse_pkg::FWSE_K_IDLE && key1_hit) begin
			key <= fwse_pkg::FWSE_K_FIRST;
		end else if (key == fwse_pkg::FWSE_K_FIRST && key2_hit) begin
			key <= fwse_pkg::FWSE_K_ARMED;
		end else if (armed && wr_req) begin
			key <= fwse_pkg::FWSE_K_IDLE;
		end
	end

	// ****************************************************************
	// Control bits
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_sel   <= 1'b0;
			latch_only_select      <= 1'b0;
			erase_sel <= 1'b0;
			program_erase_enable      <= 1'b0;
		end else if (i_dev_rst) begin
			cfg_sel   <= 1'b0;
			latch_only_select      <= 1'b0;
			erase_sel <= 1'b0;
			program_erase_enable      <= 1'b0;
		end else if (i_ctrl_we && idle) begin
			cfg_sel   <= new_cfg;
			latch_only_select      <= new_latch_only_select;
			erase_sel <= new_erase;
			program_erase_enable      <= i_ctrl_wdata[`FWSE_CB_PROGRAM_ERASE_ENABLE];
		end else if (ewait_end) begin
			erase_sel <= 1'b0;
		end
	end

	// A zero written while busy is ignored because writes need idle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr <= 1'b0;
		end else if (i_dev_rst) begin
			wr <= 1'b0;
		end else if (accept) begin
			wr <= 1'b1;
		end else if (op_end || state == fwse_pkg::FWSE_LOAD) begin
			wr <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd <= 1'b0;
		end else if (i_dev_rst) begin
			rd <= 1'b0;
		end else if (rd_req) begin
			rd <= 1'b1;
		end else if (state == fwse_pkg::FWSE_READ) begin
			rd <= 1'b0;
		end
	end

	// The error flag survives device resets so software can see why.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			werr <= 1'b0;
		end else if (hw_err) begin
			werr <= 1'b1;
		end else if (i_ctrl_we) begin
			werr <= i_ctrl_wdata[`FWSE_CB_WERR];
		end
	end

	always_comb begin
		next_done = o_mem_op_done_flag;
		if (i_done_clr) begin
			next_done = 1'b0;
		end
		if (op_end) begin
			next_done = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_op_done_flag <= 1'b0;
			o_irq              <= 1'b0;
		end else begin
			o_mem_op_done_flag <= next_done;
			o_irq              <= next_done & i_done_ie;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= fwse_pkg::FWSE_IDLE;
			idx   <= '0;
		end else if (i_dev_rst) begin
			state <= fwse_pkg::FWSE_IDLE;
			idx   <= '0;
		end else begin
			case (state)
			fwse_pkg::FWSE_IDLE: begin
				idx <= '0;
				if (accept && new_erase) begin
					state <= fwse_pkg::FWSE_EWAIT;
				end else if (accept && new_latch_only_select) begin
					state <= fwse_pkg::FWSE_LOAD;
				end else if (accept) begin
					state <= fwse_pkg::FWSE_PROG;
				end else if (rd_req) begin
					state <= fwse_pkg::FWSE_READ;
				end
			end
			fwse_pkg::FWSE_READ:  state <= fwse_pkg::FWSE_IDLE;
			fwse_pkg::FWSE_LOAD:  state <= fwse_pkg::FWSE_IDLE;
			fwse_pkg::FWSE_EWAIT: begin
				if (i_fl_done) begin
					state <= fwse_pkg::FWSE_IDLE;
				end
			end
			fwse_pkg::FWSE_PROG: begin
				idx <= idx + 1'b1;
				if (idx == LAST_IDX) begin
					state <= fwse_pkg::FWSE_PWAIT;
				end
			end
			fwse_pkg::FWSE_PWAIT: begin
				if (pwait_end) begin
					state <= fwse_pkg::FWSE_IDLE;
				end
			end
			default: state <= fwse_pkg::FWSE_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Write latches
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lat_we    <= 1'b0;
			lat_waddr <= '0;
			lat_wdata <= '0;
		end else begin
			lat_we    <= accept & is_load;
			lat_waddr <= o_flash_addr[IW-1:0];
			lat_wdata <= o_flash_word;
		end
	end

	// A valid mask clears in one cycle where the memory could not.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			loaded <= '0;
		end else if (op_end) begin
			loaded <= '0;
		end else if (accept && is_load) begin
			loaded[o_flash_addr[IW-1:0]] <= 1'b1;
		end
	end

	// ****************************************************************
	// Flash side
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_v           <= 1'b0;
			s1_ld          <= 1'b0;
			s1_idx         <= '0;
			o_fl_prog_we   <= 1'b0;
			o_fl_prog_addr <= '0;
			o_fl_prog_data <= '0;
			o_fl_erase     <= 1'b0;
		end else begin
			s1_v           <= (state == fwse_pkg::FWSE_PROG);
			s1_ld          <= loaded[idx];
			s1_idx         <= idx;
			o_fl_prog_we   <= s1_v;
			o_fl_prog_addr <= {o_flash_addr[AW-1:IW], s1_idx};
			o_fl_prog_data <= s1_ld ? lat.rdata : `FWSE_BLANK;
			o_fl_erase     <= accept & new_erase;
		end
	end

	// ****************************************************************
	// Address and data pair
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flash_addr <= '0;
		end else if (i_addr_we && idle) begin
			o_flash_addr <= i_addr_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flash_word <= '0;
		end else if (state == fwse_pkg::FWSE_READ) begin
			if (cfg_sel && !cfg_readable(o_flash_addr)) begin
				o_flash_word <= '0;
			end else begin
				o_flash_word <= i_fl_rdata;
			end
		end else if (i_data_we) begin
			o_flash_word <= i_data_wdata;
		end
	end

	assign o_fl_cfg = cfg_sel;
	assign o_ctrl   = {1'b0, cfg_sel, latch_only_select, erase_sel, werr, program_erase_enable, wr, rd};

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b || i_dev_rst);

	AST_LOAD_ONLY:
	assert property (accept && is_load |=> lat_we && !o_fl_erase
		##1 !wr && !o_fl_prog_we)
		else $error("latch load did not finish in one cycle");
	AST_PROG_STREAM:
	assert property (accept && !new_latch_only_select && !new_erase |=>
		(state == fwse_pkg::FWSE_PROG)[*8] ##2 o_fl_prog_we)
		else $error("program did not stream latch words");
	AST_ERASE_PULSE:
	assert property (accept && new_erase |=> o_fl_erase ##1 !o_fl_erase)
		else $error("erase pulse not exactly one cycle");
	AST_PROT_BLOCK:
	assert property (blocked |=> !wr && werr && idle && !o_fl_erase)
		else $error("protected target was not refused");
	AST_NEED_UNLOCK:
	assert property (idle && wr_req && !armed |=> !wr && idle)
		else $error("start taken without unlock");
	AST_BLANK_AFTER:
	assert property (op_end |=> loaded == '0)
		else $error("latches not blank after operation");
	AST_READ_NEXT:
	assert property (rd_req |=> rd ##1 !rd && idle)
		else $error("read did not complete next cycle");
	AST_CFG_ZERO:
	assert property (state == fwse_pkg::FWSE_READ && cfg_sel &&
		!cfg_readable(o_flash_addr) |=> o_flash_word == '0)
		else $error("undefined config read not zero");
	AST_ERR_STICKY:
	assert property (werr && !i_ctrl_we |=> werr)
		else $error("error flag cleared by hardware");
	AST_DONE_SET:
	assert property (op_end |=> o_mem_op_done_flag ##1
		(o_irq == i_done_ie) || $past(i_done_clr))
		else $error("done flag not raised on completion");
	AST_NO_AUTO_ERASE:
	assert property (state == fwse_pkg::FWSE_PROG |-> !o_fl_erase)
		else $error("erase during program");

	COV_LOAD: cover property (accept && is_load);
	COV_PROG: cover property (pwait_end);
	COV_ERASE: cover property (ewait_end);
	COV_BROKEN: cover property (seq_broken);
endmodule // fwse_seq

// >>> src/fwse_defines.svh
// Constants of the flash row write and erase sequencer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef FWSE_DEFINES_SVH
`define FWSE_DEFINES_SVH

`define FWSE_ROW_WORDS 32
`define FWSE_BLANK     14'h3fff
`define FWSE_KEY1      8'h55
`define FWSE_KEY2      8'haa
`define FWSE_CTRL_RST  8'h00

// Control word bit positions.
`define FWSE_CB_CFG    6
`define FWSE_CB_LATCH_ONLY_SELECT   5
`define FWSE_CB_FREE   4
`define FWSE_CB_WERR   3
`define FWSE_CB_PROGRAM_ERASE_ENABLE   2
`define FWSE_CB_WR     1
`define FWSE_CB_RD     0

// Configuration-space windows, addresses with the space bit stripped.
`define FWSE_UID_LO    15'h0000
`define FWSE_UID_HI    15'h0003
`define FWSE_ID_LO     15'h0005
`define FWSE_CFGW_HI   15'h000b
`define FWSE_DIA_LO    15'h0100
`define FWSE_DIA_HI    15'h02ff

`endif

// >>> src/fwse_pkg.sv
// Types of the flash row write and erase sequencer.
// Assumes nothing of its surroundings.
package fwse_pkg;
	typedef enum logic [2:0] {
		FWSE_IDLE  = 3'b000,
		FWSE_READ  = 3'b001,
		FWSE_LOAD  = 3'b010,
		FWSE_EWAIT = 3'b011,
		FWSE_PROG  = 3'b100,
		FWSE_PWAIT = 3'b101
	} fwse_state_e;
	typedef enum logic [1:0] {
		FWSE_K_IDLE  = 2'b00,
		FWSE_K_FIRST = 2'b01,
		FWSE_K_ARMED = 2'b10
	} fwse_key_e;
endpackage

// >>> src/fwse_latch_if.sv
// Carrier between the sequencer and its write latch memory.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
interface fwse_latch_if #(
	parameter int AW = 5,
	parameter int DW = 14
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// >>> src/fwse_latch_mem.sv
// Row write latch storage with a registered read port.
// Assumes the sequencer tracks which entries hold data.
`timescale 1ns/1ps
module fwse_latch_mem #(
	parameter int DEPTH = 32,
	parameter int AW    = 5,
	parameter int DW    = 14
)(
	input  wire logic i_clk,
	fwse_latch_if.mem lp
);
	if (DEPTH != (1 << AW)) begin : g_chk
		$error("fwse_latch_mem: DEPTH must equal 2**AW");
	end

	logic [DW-1:0] store [DEPTH];

	// Contents need no reset: blank entries are masked by the owner.
	always_ff @(posedge i_clk) begin
		if (lp.we) begin
			store[lp.waddr] <= lp.wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		lp.rdata <= store[lp.raddr];
	end
endmodule // fwse_latch_mem

// >>> test/test_flash_row_write_erase_sequencer.sv
// Self-checking bench for the flash row write and erase sequencer.
// Assumes the sequencer's port list; the bench plays both CPU and array.
`timescale 1ns/1ps
module test_flash_row_write_erase_sequencer;
	logic        i_clk = 0, i_rst_b = 0, i_dev_rst = 0;
	logic        i_addr_we = 0, i_data_we = 0, i_ctrl_we = 0, i_key_we = 0;
	logic [14:0] i_addr_wdata = 0;
	logic [13:0] i_data_wdata = 0, i_fl_rdata = 0;
	logic [7:0]  i_ctrl_wdata = 0, i_key_wdata = 0;
	logic        i_seq_break = 0, i_done_clr = 0, i_done_ie = 0;
	logic        i_fl_wp = 0, i_fl_done = 0;
	logic [14:0] o_flash_addr, o_fl_prog_addr, er_addr;
	logic [13:0] o_flash_word, o_fl_prog_data;
	logic [7:0]  o_ctrl;
	logic        o_mem_op_done_flag, o_irq, o_fl_cfg, o_fl_erase, o_fl_prog_we;
	logic [14:0] cap_a [64];
	logic [13:0] cap_d [64];
	logic [13:0] lat   [32];
	int          n_prog = 0, n_erase = 0, n_errors = 0, num_checks = 0;

	fwse_seq u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_dev_rst(i_dev_rst),
		.i_addr_we(i_addr_we), .i_addr_wdata(i_addr_wdata),
		.i_data_we(i_data_we), .i_data_wdata(i_data_wdata),
		.i_ctrl_we(i_ctrl_we), .i_ctrl_wdata(i_ctrl_wdata),
		.i_key_we(i_key_we), .i_key_wdata(i_key_wdata),
		.i_seq_break(i_seq_break), .i_done_clr(i_done_clr),
		.i_done_ie(i_done_ie), .i_fl_rdata(i_fl_rdata), .i_fl_wp(i_fl_wp),
		.i_fl_done(i_fl_done), .o_flash_addr(o_flash_addr),
		.o_flash_word(o_flash_word), .o_ctrl(o_ctrl),
		.o_mem_op_done_flag(o_mem_op_done_flag), .o_irq(o_irq),
		.o_fl_cfg(o_fl_cfg), .o_fl_erase(o_fl_erase),
		.o_fl_prog_we(o_fl_prog_we), .o_fl_prog_addr(o_fl_prog_addr),
		.o_fl_prog_data(o_fl_prog_data));

	always #20 i_clk = ~i_clk;

	// ********************************
	// Array side monitor
	// ********************************
	always @(posedge i_clk) begin
		if (o_fl_prog_we === 1'b1) begin
			cap_a[n_prog % 64] = o_fl_prog_addr;
			cap_d[n_prog % 64] = o_fl_prog_data;
			n_prog++;
		end
		if (o_fl_erase === 1'b1) begin
			er_addr = o_flash_addr;
			n_erase++;
		end
	end

	// ********************************
	// Helpers
	// ********************************
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic set_addr(input logic [14:0] v);
		@(posedge i_clk);
		i_addr_we <= 1;
		i_addr_wdata <= v;
		@(posedge i_clk);
		i_addr_we <= 0;
	endtask

	task automatic set_data(input logic [13:0] v);
		@(posedge i_clk);
		i_data_we <= 1;
		i_data_wdata <= v;
		@(posedge i_clk);
		i_data_we <= 0;
	endtask

	task automatic set_ctrl(input logic [7:0] v);
		@(posedge i_clk);
		i_ctrl_we <= 1;
		i_ctrl_wdata <= v;
		@(posedge i_clk);
		i_ctrl_we <= 0;
		#1;
	endtask

	task automatic pulse_done();
		@(posedge i_clk);
		i_fl_done <= 1;
		@(posedge i_clk);
		i_fl_done <= 0;
	endtask

	// Mode 1 takes an interrupt between the keys, mode 2 sends a bad key.
	task automatic unlock(input logic [7:0] c, input int brk);
		@(posedge i_clk);
		i_key_we <= 1;
		i_key_wdata <= 8'h55;
		@(posedge i_clk);
		if (brk == 1) begin
			i_key_we <= 0;
			i_seq_break <= 1;
			@(posedge i_clk);
			i_seq_break <= 0;
			i_key_we <= 1;
		end
		i_key_wdata <= (brk == 2) ? 8'hab : 8'haa;
		@(posedge i_clk);
		#1;
		if (brk != 0)
			chk(o_ctrl[3], 1);
		i_key_we <= 0;
		i_ctrl_we <= 1;
		i_ctrl_wdata <= c;
		@(posedge i_clk);
		i_ctrl_we <= 0;
	endtask

	task automatic wait_idle();
		for (int k = 0; k < 200 && o_ctrl[1] !== 1'b0; k++) step(1);
		chk(o_ctrl[1], 0);
	endtask

	task automatic done_clear();
		step(1);
		chk(o_mem_op_done_flag, 1);
		chk(o_irq, 1);
		@(posedge i_clk);
		i_done_clr <= 1;
		@(posedge i_clk);
		i_done_clr <= 0;
		step(2);
		chk(o_mem_op_done_flag, 0);
		for (int i = 0; i < 32; i++) lat[i] = 14'h3fff;
	endtask

	task automatic load(input logic [4:0] idx, input logic [9:0] row);
		logic [13:0] d;
		d = 14'($urandom);
		set_addr({row, idx});
		set_data(d);
		unlock(8'h26, 0);
		#1;
		chk(o_ctrl[1], 1);
		wait_idle();
		lat[idx] = d;
	endtask

	task automatic do_prog(input logic [14:0] a, input logic [7:0] c);
		int base;
		int eb;
		base = n_prog;
		eb = n_erase;
		set_addr(a);
		set_data(14'($urandom));
		unlock(c, 0);
		set_ctrl(8'h04);
		chk(o_ctrl[1], 1);
		for (int k = 0; k < 100 && n_prog < base + 32; k++) step(1);
		chk(n_prog - base, 32);
		for (int i = 0; i < 32; i++) begin
			chk(cap_a[(base + i) % 64], {a[14:5], 5'(i)});
			chk(cap_d[(base + i) % 64], lat[i]);
		end
		pulse_done();
		wait_idle();
		chk(n_erase - eb, 0);
		done_clear();
	endtask

	task automatic do_erase(input logic [14:0] a);
		int base;
		int eb;
		base = n_prog;
		eb = n_erase;
		set_addr(a);
		unlock(8'h16, 0);
		for (int k = 0; k < 50 && n_erase == eb; k++) step(1);
		chk(n_erase - eb, 1);
		chk(er_addr[14:5], a[14:5]);
		pulse_done();
		wait_idle();
		chk(o_ctrl[4], 0);
		chk(n_prog - base, 0);
		done_clear();
	endtask

	// ********************************
	// Tests
	// ********************************
	localparam logic [14:0] CA [6] = '{15'h0002, 15'h0004, 15'h0007,
		15'h0050, 15'h0200, 15'h0300};
	localparam logic [5:0] CIN = 6'b010101;

	initial begin
		#(40 * 20000);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(11364));
		for (int i = 0; i < 32; i++) lat[i] = 14'h3fff;
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1;
		i_done_ie <= 1;
		step(1);
		chk(o_ctrl, 8'h00);
		chk(o_mem_op_done_flag, 0);
		// Loads wiped by an erase must program as blank.
		for (int k = 0; k < 4; k++) load(5'($urandom), 10'($urandom));
		do_erase(15'($urandom));
		do_prog(15'($urandom), 8'h06);
		// Protection does not apply to latch loads; edge indexes included.
		i_fl_wp <= 1;
		for (int k = 0; k < 6; k++)
			load((k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom), 10'h3);
		chk(o_ctrl[3], 0);
		i_fl_wp <= 0;
		do_prog({10'($urandom), 5'h1f}, 8'h06);
		// A broken unlock must leave latches and flag as expected.
		for (int b = 1; b <= 2; b++) begin
			set_addr(15'($urandom));
			unlock(8'h26, b);
			step(3);
			chk(o_ctrl[1], 0);
			// The refused start write carried a clear error bit.
			chk(o_ctrl[3], 0);
			set_ctrl(8'h00);
			chk(o_ctrl[3], 0);
		end
		do_prog(15'($urandom), 8'h06);
		set_ctrl(8'h08);
		chk(o_ctrl[3], 1);
		@(posedge i_clk);
		i_dev_rst <= 1;
		@(posedge i_clk);
		i_dev_rst <= 0;
		step(2);
		chk(o_ctrl[3], 1);
		// Protected program in flash, then erase of a read-only config word.
		for (int p = 0; p < 2; p++) begin
			int base;
			int eb;
			base = n_prog;
			eb = n_erase;
			set_ctrl(8'h00);
			i_fl_wp <= (p == 0);
			set_addr((p == 0) ? 15'($urandom) : 15'h0005);
			unlock((p == 0) ? 8'h06 : 8'h56, 0);
			step(3);
			chk(o_ctrl[1], 0);
			chk(o_ctrl[3], 1);
			chk(n_prog - base + n_erase - eb, 0);
		end
		i_fl_wp <= 0;
		set_ctrl(8'h00);
		// Reads from flash and from the configuration space.
		for (int r = 0; r < 7; r++) begin
			logic [13:0] d;
			d = 14'($urandom);
			i_fl_rdata <= d;
			set_addr((r == 6) ? 15'($urandom) : CA[r % 6]);
			set_ctrl((r == 6) ? 8'h01 : 8'h41);
			step(2);
			chk(o_ctrl[0], 0);
			chk(o_flash_word, (r == 6 || CIN[r]) ? d : 14'h0);
		end
		// User ID words take a row program in configuration space.
		load(5'h01, 10'h0);
		do_prog(15'h0002, 8'h46);
		chk(o_ctrl[3], 0);
		// A device reset in mid-program flags an error.
		set_addr(15'($urandom));
		unlock(8'h06, 0);
		step(6);
		@(posedge i_clk);
		i_dev_rst <= 1;
		@(posedge i_clk);
		i_dev_rst <= 0;
		step(2);
		chk(o_ctrl[1], 0);
		chk(o_ctrl[3], 1);
		tally_and_finish();
	end
endmodule // test_flash_row_write_erase_sequencer
